// *** verilog/system_watchdog_timer.sv ***
// Purpose: watchdog timer with axi4-lite register slave
// Assumes: aclk at 125 MHz, cpu_idle synchronous to aclk
// Notes: expiry raises a non-maskable request or a reset request
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
module system_watchdog_timer
  import wdt_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_idle,
  output logic watchdog_nmi_request,
  output logic watchdog_reset_request
);
  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } slave_s;
  slave_s state_reg;
  slave_s state_next;
  logic do_write;
  logic [7:0] rd_word;
  wdt_bus_if bus ();
  // ---------------------------------------------------------------
  // counter core
  // ---------------------------------------------------------------
  wdt_counter_core core_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .cpu_idle(cpu_idle),
    .bus(bus),
    .watchdog_nmi_request(watchdog_nmi_request),
    .watchdog_reset_request(watchdog_reset_request)
  );
  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  assign s_axi_awready = !state_reg.aw_held && !state_reg.bvalid;
  assign s_axi_wready = !state_reg.w_held && !state_reg.bvalid;
  assign s_axi_arready = !state_reg.rvalid;
  assign do_write = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
  assign rd_word = {state_reg.awaddr[7:2], 2'b00};
  always_comb begin
    state_next = state_reg;
    bus.wr_mode = 1'b0;
    bus.wr_key = 1'b0;
    bus.wr_clear = 1'b0;
    bus.wdata = state_reg.wdata;
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_held = 1'b1;
      state_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_held = 1'b1;
      state_next.wdata = s_axi_wdata;
    end
    if (do_write) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = resp_okay;
      case (rd_word)
        mode_offset: bus.wr_mode = 1'b1;
        key_offset: bus.wr_key = 1'b1;
        clear_offset: bus.wr_clear = 1'b1;
        status_offset: state_next.bresp = resp_okay;
        default: state_next.bresp = resp_slverr;
      endcase
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = resp_okay;
      case ({s_axi_araddr[7:2], 2'b00})
        mode_offset: state_next.rdata = bus.mode_word & mode_rd_mask;
        key_offset: state_next.rdata = 32'h0;
        clear_offset: state_next.rdata = 32'h0;
        status_offset: state_next.rdata = {30'h0, bus.expired, bus.running};
        default: begin
          state_next.rdata = 32'h0;
          state_next.rresp = resp_slverr;
        end
      endcase
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
endmodule

// *** verilog/wdt_pkg.sv ***
// Purpose: constants shared by the watchdog design files
// Assumes: 32-bit axi4-lite register bus, one clock
// Notes: offsets are byte addresses
package wdt_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] mode_offset = 8'h00;
  localparam logic [7:0] key_offset = 8'h04;
  localparam logic [7:0] status_offset = 8'h08;
  localparam logic [7:0] clear_offset = 8'h0c;
  // ---------------------------------------------------------------
  // mode register fields
  // ---------------------------------------------------------------
  localparam int enable_pos = 7;
  localparam int period_lsb = 4;
  localparam int idle_pos = 2;
  localparam int action_pos = 1;
  localparam logic enable_reset = 1'b1;
  localparam logic [2:0] period_reset = 3'h0;
  localparam logic idle_reset = 1'b0;
  localparam logic action_reset = 1'b1;
  localparam logic [31:0] mode_rd_mask = 32'h0000_00f6;
  // ---------------------------------------------------------------
  // key codes, timing and bus response codes
  // ---------------------------------------------------------------
  localparam logic [7:0] disable_key = 8'hb1;
  localparam logic [7:0] clear_key = 8'h4e;
  localparam int period_base_log2 = 15;
  localparam int period_step_log2 = 2;
  localparam logic [2:0] period_max_code = 3'h5;
  localparam int counter_width = 26;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// *** verilog/wdt_bus_if.sv ***
// Purpose: register-write and mode/status readback carrier between slave and core
// Assumes: single clock
// Notes: none
`timescale 1ns/100ps
interface wdt_bus_if;
  logic wr_mode;
  logic wr_key;
  logic wr_clear;
  logic [31:0] wdata;
  logic [31:0] mode_word;
  logic running;
  logic expired;
  modport slave (output wr_mode, output wr_key, output wr_clear, output wdata,
    input mode_word, input running, input expired);
  modport core (input wr_mode, input wr_key, input wr_clear, input wdata,
    output mode_word, output running, output expired);
endinterface

// *** verilog/wdt_counter_core.sv ***
// Purpose: watchdog mode register, run state and period counter
// Assumes: idle indication comes from logic on the same clock
// Notes: expiry actions are single-cycle pulses
`timescale 1ns/100ps
module wdt_counter_core
  import wdt_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cpu_idle,
  wdt_bus_if.core bus,
  output logic watchdog_nmi_request,
  output logic watchdog_reset_request
);
  typedef struct packed {
    logic en;
    logic [2:0] period;
    logic idle_run;
    logic action;
    logic running;
    logic expired;
    logic [counter_width-1:0] count;
    logic nmi;
    logic rst;
  } core_s;
  core_s state_reg;
  core_s state_next;
  logic [counter_width-1:0] limit;
  logic counting;
  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.nmi = 1'b0;
    state_next.rst = 1'b0;
    limit = counter_width'((64'd1 << (period_base_log2 +
      period_step_log2 * int'(state_reg.period))) - 64'd1);
    counting = state_reg.running && (state_reg.period <= period_max_code) &&
      (!cpu_idle || state_reg.idle_run);
    if (bus.wr_mode) begin
      state_next.en = bus.wdata[enable_pos];
      state_next.period = bus.wdata[period_lsb +: 3];
      state_next.idle_run = bus.wdata[idle_pos];
      state_next.action = bus.wdata[action_pos];
      if (bus.wdata[enable_pos]) begin
        state_next.running = 1'b1;
      end
    end
    if (bus.wr_key && bus.wdata[7:0] == disable_key && !state_reg.en) begin
      state_next.running = 1'b0;
      state_next.count = '0;
    end
    if (bus.wr_key && bus.wdata[7:0] == clear_key) begin
      state_next.count = '0;
    end else if (bus.wr_clear) begin
      state_next.expired = 1'b0;
    end
    if (counting && !(bus.wr_key && bus.wdata[7:0] == clear_key)) begin
      if (state_reg.count >= limit) begin
        state_next.count = '0;
        state_next.expired = 1'b1;
        if (state_reg.action) begin
          state_next.rst = 1'b1;
        end else begin
          state_next.nmi = 1'b1;
        end
      end else begin
        state_next.count = state_reg.count + 1'b1;
      end
    end
  end
  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.en <= enable_reset;
      state_reg.period <= period_reset;
      state_reg.idle_run <= idle_reset;
      state_reg.action <= action_reset;
      state_reg.running <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end
  assign bus.mode_word = {24'h0, state_reg.en, state_reg.period, 1'b0,
    state_reg.idle_run, state_reg.action, 1'b0};
  assign bus.running = state_reg.running;
  assign bus.expired = state_reg.expired;
  assign watchdog_nmi_request = state_reg.nmi;
  assign watchdog_reset_request = state_reg.rst;
endmodule

// *** bench/wdt_chk.sv ***
// Purpose: bus timing and expiry checks on the top ports
// Assumes: one clock, synchronous active-low reset
// Notes: bound from tb
`timescale 1ns/100ps
module wdt_chk
  import wdt_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic watchdog_nmi_request,
  input wire logic watchdog_reset_request
);
  // cycles since reset or last expiry
  logic [25:0] gap_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || watchdog_nmi_request || watchdog_reset_request) begin
      gap_reg <= 26'h0;
    end else begin
      gap_reg <= gap_reg + 26'h1;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_due;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_write_resp_time: assert property (wr_taken |=> resp_due) else $error("late write response");
  a_read_resp_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read data");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_nmi_one_cycle: assert property (watchdog_nmi_request |=> !watchdog_nmi_request)
    else $error("nmi pulse too long");
  a_reset_one_cycle: assert property (watchdog_reset_request |=> !watchdog_reset_request)
    else $error("reset pulse too long");
  a_action_exclusive: assert property (!(watchdog_nmi_request && watchdog_reset_request))
    else $error("both expiry actions");
  a_period_min: assert property ((watchdog_nmi_request || watchdog_reset_request) |-> gap_reg >= 26'h7fff)
    else $error("expiry too early");
  a_quiet_start: assert property ($rose(aresetn) |-> !(watchdog_nmi_request || watchdog_reset_request) [*8])
    else $error("expiry right after reset");
endmodule

// *** bench/tb.sv ***
// Purpose: self-checking bench for the watchdog
// Assumes: period code 0 keeps the run short
// Notes: mode model kept in mode_m
`timescale 1ns/100ps
module tb;
  import wdt_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic cpu_idle = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic watchdog_nmi_request, watchdog_reset_request;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, mode_m, rv;
  logic [1:0] rr;
  int error_cnt = 0;
  int samples_checked = 0;
  int n;
  integer seed = 32'h3ea300fe;
  system_watchdog_timer system_watchdog_timer_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_idle, .watchdog_nmi_request,
    .watchdog_reset_request);
  always #4 aclk = ~aclk;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] mask);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata & mask;
    rr = s_axi_rresp;
  endtask
  task wait_req(input logic want_nmi);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!(want_nmi ? watchdog_nmi_request : watchdog_reset_request) && n < 40000);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge aclk);
    error_cnt++;
    wrap_up;
  end
  initial begin
    mode_m = 32'h82;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (500) @(posedge aclk);
    cpu_idle <= 1'b0;
    rd(mode_offset, 32'hffffffff);
    chk(rv, mode_m);
    chk({30'h0, rr}, {30'h0, resp_okay});
    wait_req(1'b0);
    chk({31'h0, n > 32700 && n < 32800}, 32'h1);
    wr(mode_offset, 32'h84, resp_okay);
    cpu_idle <= 1'b1;
    wait_req(1'b1);
    chk({31'h0, n > 32700 && n < 32800}, 32'h1);
    wr(key_offset, {24'h0, disable_key}, resp_okay);
    rd(status_offset, 32'h3);
    chk(rv, 32'h3);
    wr(clear_offset, 32'h0, resp_okay);
    rd(status_offset, 32'h3);
    chk(rv, 32'h1);
    mode_m = $random(seed) & 32'h5f;
    wr(mode_offset, mode_m, resp_okay);
    rd(mode_offset, 32'hffffffff);
    chk(rv, mode_m & mode_rd_mask);
    rd(status_offset, 32'h1);
    chk(rv, 32'h1);
    wr(key_offset, {24'h0, disable_key}, resp_okay);
    rd(status_offset, 32'h1);
    chk(rv, 32'h0);
    wr(mode_offset, 32'h80, resp_okay);
    rd(status_offset, 32'h1);
    chk(rv, 32'h1);
    wr(8'h10, 32'h0, resp_slverr);
    rd(8'h10, 32'hffffffff);
    chk(rv, 32'h0);
    chk({30'h0, rr}, {30'h0, resp_slverr});
    rd(key_offset, 32'hffffffff);
    chk(rv, 32'h0);
    chk({30'h0, rr}, {30'h0, resp_okay});
    wrap_up;
  end
endmodule
bind system_watchdog_timer wdt_chk wdt_chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .watchdog_nmi_request,
  .watchdog_reset_request);
